//--- rtl/dipr_pkg.sv
// constants for the dac input port routing block
// assumes a 50 MHz core clock and a 160 ns channel clock period
package dipr_pkg;
    localparam int WORD_W = 16;
    localparam int Q_MSB_POS = 15;
    localparam int Q_BIT14_POS = 14;
    localparam int LOW_W = 14;
    localparam int FIFO_DEPTH = 32;
    // fifo entry: {i_valid, q_valid, i_word, q_word}
    localparam int ENTRY_W = 2 * WORD_W + 2;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CHAN_PERIOD_NS = 160;
    // half channel period in core cycles, rounded down
    localparam int CHAN_HALF_CYC = CHAN_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // high time of the double-rate clock: half of a half period
    localparam int DBL_HIGH_CYC = (CHAN_HALF_CYC / 2 < 1) ? 1 : CHAN_HALF_CYC / 2;
    localparam int CNT_W = 8;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
endpackage : dipr_pkg

//--- rtl/dipr_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and an already synchronised active-low reset
`timescale 1ns/1ps
module dipr_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_r];

    // storage has no reset; only the pointers and the count carry state
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : dipr_fifo

//--- rtl/dipr_top.sv
// pin steering for the two sample ports and the serial pin directions
// assumes all pins are asynchronous to clock; config bits and serial
// engine signals come from logic on clock
`timescale 1ns/1ps
module dipr_top (
    input wire logic clock,
    input wire logic rst_n,
    // configuration bits
    input wire logic single_port_mode,
    input wire logic channel_select_polarity,
    input wire logic sample_clock_direction,
    input wire logic serial_pin_direction,
    // sample pins
    input wire logic [15:0] first_port_bits,
    input wire logic second_port_msb,
    input wire logic second_port_bit14_in,
    output logic double_rate_clock_out,
    output logic double_rate_clock_oe,
    input wire logic [13:0] second_port_low_bits,
    input wire logic sample_clock_pin_in,
    output logic sample_clock_pin_out,
    output logic sample_clock_pin_oe,
    // routed words toward the channel paths
    output logic out_valid,
    input wire logic out_ready,
    output logic out_i_valid,
    output logic out_q_valid,
    output logic [15:0] out_i_word,
    output logic [15:0] out_q_word,
    output logic overflow,
    // serial pins
    input wire logic serial_select_n,
    input wire logic instr_read,
    input wire logic read_data,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic serial_write_data,
    output logic serial_read_pin_out,
    output logic serial_read_pin_oe
);
    localparam int WW = dipr_pkg::WORD_W;
    localparam int EW = dipr_pkg::ENTRY_W;
    localparam int CW = dipr_pkg::CNT_W;

    // true when a single-port word belongs to the Q channel
    function automatic logic word_is_q(input logic sel, input logic pol);
        return sel == pol;
    endfunction : word_is_q

    logic rst_s1_r;
    logic rst_s2_r;
    logic rst_int_n;
    logic [WW-1:0] p1_s1_r;
    logic [WW-1:0] p1_s2_r;
    logic [WW-1:0] p2_s1_r;
    logic [WW-1:0] p2_s2_r;
    logic sclk_s1_r;
    logic sclk_s2_r;
    logic sclk_d_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic sdi_s1_r;
    logic sdi_s2_r;
    logic [CW-1:0] div_cnt_r;
    logic int_clk_r;
    logic int_clk_d_r;
    logic [CW-1:0] dbl_cnt_r;
    logic dbl_r;
    logic chan_level;
    logic chan_prev;
    logic rise;
    logic any_edge;
    logic latch;
    logic [WW-1:0] q_word;
    logic [EW-1:0] entry_nxt;
    logic fifo_in_ready;
    logic [EW-1:0] fifo_out_data;
    logic overflow_r;
    logic [2:0] prime_r;

    // reset asserts at once and releases after two clock edges
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_int_n = rst_s2_r;

    // two-stage synchronisers for every pin input
    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            p1_s1_r <= dipr_pkg::WORD_RST;
            p1_s2_r <= dipr_pkg::WORD_RST;
            p2_s1_r <= dipr_pkg::WORD_RST;
            p2_s2_r <= dipr_pkg::WORD_RST;
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end else begin
            p1_s1_r <= first_port_bits;
            p1_s2_r <= p1_s1_r;
            p2_s1_r <= {second_port_msb, second_port_bit14_in, second_port_low_bits};
            p2_s2_r <= p2_s1_r;
            sclk_s1_r <= sample_clock_pin_in;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
            cs_s1_r <= serial_select_n;
            cs_s2_r <= cs_s1_r;
            sdi_s1_r <= serial_data_in;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    // internal channel-rate clock, driven out when the pin is an output
    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            div_cnt_r <= '0;
            int_clk_r <= 1'b0;
            int_clk_d_r <= 1'b0;
        end else begin
            int_clk_d_r <= int_clk_r;
            if (div_cnt_r == CW'(dipr_pkg::CHAN_HALF_CYC - 1)) begin
                div_cnt_r <= '0;
                int_clk_r <= ~int_clk_r;
            end else begin
                div_cnt_r <= div_cnt_r + 1'b1;
            end
        end
    end
    assign sample_clock_pin_out = int_clk_r;
    assign sample_clock_pin_oe = sample_clock_direction;

    // pick the channel clock: sampled pin or own divider
    assign chan_level = sample_clock_direction ? int_clk_r : sclk_s2_r;
    assign chan_prev = sample_clock_direction ? int_clk_d_r : sclk_d_r;
    // the clock synchroniser resets low, so a pin already high at release would
    // look like an edge; edges count only once the pipeline holds real samples
    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            prime_r <= 3'h0;
        end else begin
            prime_r <= {prime_r[1:0], 1'b1};
        end
    end
    assign rise = prime_r[2] && chan_level && !chan_prev;
    assign any_edge = prime_r[2] && (chan_level != chan_prev);
    // single-port words come twice per channel period, so both edges latch
    assign latch = single_port_mode ? any_edge : rise;

    // double-rate clock: high pulse at every channel edge
    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            dbl_cnt_r <= '0;
            dbl_r <= 1'b0;
        end else if (any_edge) begin
            dbl_cnt_r <= CW'(dipr_pkg::DBL_HIGH_CYC - 1);
            dbl_r <= 1'b1;
        end else if (dbl_cnt_r != '0) begin
            dbl_cnt_r <= dbl_cnt_r - 1'b1;
        end else begin
            dbl_r <= 1'b0;
        end
    end
    assign double_rate_clock_out = dbl_r;
    // the shared pin only drives in single-port mode; otherwise it is Q bit 14
    assign double_rate_clock_oe = single_port_mode;

    // Q word from the second port: select pin on top, shared pin below
    assign q_word = {p2_s2_r[dipr_pkg::Q_MSB_POS],
                     p2_s2_r[dipr_pkg::Q_BIT14_POS],
                     p2_s2_r[dipr_pkg::LOW_W-1:0]};

    // build one fifo entry per latch event
    always_comb begin
        if (!single_port_mode) begin
            entry_nxt = {1'b1, 1'b1, p1_s2_r, q_word};
        end else if (word_is_q(p2_s2_r[dipr_pkg::Q_MSB_POS], channel_select_polarity)) begin
            entry_nxt = {1'b0, 1'b1, dipr_pkg::WORD_RST, p1_s2_r};
        end else begin
            entry_nxt = {1'b1, 1'b0, p1_s2_r, dipr_pkg::WORD_RST};
        end
    end

    // the pins cannot be stalled, so a word meeting a full fifo is lost
    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            overflow_r <= 1'b0;
        end else if (latch && !fifo_in_ready) begin
            overflow_r <= 1'b1;
        end
    end
    assign overflow = overflow_r;

    dipr_fifo #(
        .WIDTH(EW),
        .DEPTH(dipr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_int_n),
        .in_valid(latch),
        .in_ready(fifo_in_ready),
        .in_data(entry_nxt),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out_data)
    );
    assign out_i_valid = fifo_out_data[EW-1];
    assign out_q_valid = fifo_out_data[EW-2];
    assign out_i_word = fifo_out_data[2*WW-1:WW];
    assign out_q_word = fifo_out_data[WW-1:0];

    // serial pin directions, registered so the pins never glitch
    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
            serial_read_pin_out <= 1'b0;
            serial_read_pin_oe <= 1'b0;
        end else begin
            serial_data_out <= read_data;
            // three-wire mode: direction from the instruction read bit
            serial_data_oe <= !cs_s2_r && (!serial_pin_direction || instr_read);
            serial_read_pin_out <= read_data;
            serial_read_pin_oe <= !cs_s2_r && !serial_pin_direction;
        end
    end
    assign serial_write_data = sdi_s2_r;
endmodule : dipr_top

//--- sim/dipr_top_asserts.sv
// port checks for the pin steering block
// assumes one clock domain; bound into every dipr_top
`timescale 1ns/1ps
module dipr_top_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic single_port_mode,
    input wire logic sample_clock_direction,
    input wire logic serial_pin_direction,
    input wire logic serial_select_n,
    input wire logic instr_read,
    input wire logic double_rate_clock_oe,
    input wire logic double_rate_clock_out,
    input wire logic sample_clock_pin_oe,
    input wire logic out_valid,
    input wire logic out_i_valid,
    input wire logic out_q_valid,
    input wire logic overflow,
    input wire logic serial_data_oe,
    input wire logic serial_read_pin_oe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // four samples span the two sync stages and the output flop
    sequence idle_s;
        serial_select_n [*4];
    endsequence
    sequence four_s;
        (!serial_select_n && !serial_pin_direction) [*4];
    endsequence
    sequence three_s(rd);
        (!serial_select_n && serial_pin_direction && instr_read == rd) [*4];
    endsequence
    // each channel edge gives one pulse that stays high for two cycles
    sequence dbl_s;
        double_rate_clock_out ##1 !double_rate_clock_out;
    endsequence
    a_dbl_pulse: assert property ($rose(double_rate_clock_out) |=> dbl_s)
        else $error("double rate pulse malformed");
    a_dbl_oe_mode: assert property (double_rate_clock_oe == single_port_mode)
        else $error("double rate enable wrong");
    a_sclk_oe_dir: assert property (sample_clock_pin_oe == sample_clock_direction)
        else $error("sample clock enable wrong");
    a_pins_float: assert property (idle_s |-> !serial_data_oe && !serial_read_pin_oe)
        else $error("serial pin driven while idle");
    a_four_drive: assert property (four_s |-> serial_data_oe && serial_read_pin_oe)
        else $error("serial pins not driven");
    a_sdio_read: assert property (three_s(1'b1) |-> serial_data_oe && !serial_read_pin_oe)
        else $error("data pin not driven on read");
    a_sdio_write: assert property (three_s(1'b0) |-> !serial_data_oe)
        else $error("data pin driven on write");
    a_dual_pair: assert property (out_valid && !single_port_mode |-> out_i_valid && out_q_valid)
        else $error("dual entry not paired");
    a_reset_clear: assert property ($rose(rst_n) |-> !out_valid && !overflow)
        else $error("state survived reset");
endmodule : dipr_top_asserts
bind dipr_top dipr_top_asserts i_dipr_top_asserts (.*);

//--- sim/dipr_src_model.sv
// baseband source model: sample words and the channel clock pin
// assumes it is called on a falling core edge; the clock pin moves only inside put
`timescale 1ns/1ps
module dipr_src_model (
    input wire logic clock,
    output logic [15:0] first_port_bits,
    output logic second_port_msb,
    output logic second_port_bit14_in,
    output logic [13:0] second_port_low_bits,
    output logic sample_clock_pin_in
);
    logic [31:0] pins_r;
    assign {first_port_bits, second_port_msb, second_port_bit14_in, second_port_low_bits} = pins_r;
    initial begin
        pins_r = 32'h0;
        sample_clock_pin_in = 1'b0;
    end
    // word and channel edge leave together on a falling core edge, half a channel
    // period per call; the word is inverted a cycle before the next call so a late
    // sample cannot hit a stale match
    task automatic put(input logic [15:0] p1, input logic [15:0] p2);
        pins_r = {p1, p2};
        sample_clock_pin_in = ~sample_clock_pin_in;
        repeat (dipr_pkg::CHAN_HALF_CYC - 1) @(negedge clock);
        pins_r = ~{p1, p2};
        @(negedge clock);
    endtask : put
endmodule : dipr_src_model

//--- sim/tb.sv
// self-checking bench for the pin steering block
// assumes the source model owns the sample pins and channel clock pin
`timescale 1ns/1ps
module tb;
    logic clock, rst_n, single_port_mode, channel_select_polarity, sample_clock_direction;
    logic serial_pin_direction, second_port_msb, second_port_bit14_in, sample_clock_pin_in;
    logic double_rate_clock_out, out_valid, out_ready, out_i_valid, out_q_valid, overflow;
    logic serial_select_n, instr_read, serial_data_oe, serial_read_pin_oe, sample_clock_pin_oe;
    logic [15:0] first_port_bits, out_i_word, out_q_word;
    logic [13:0] second_port_low_bits;
    logic read_data, serial_data_in, serial_data_out, serial_write_data, serial_read_pin_out;
    logic sample_clock_pin_out;
    int errors, num_checks, dbl_rises, sclk_rises;
    dipr_top i_dipr_top (.*, .double_rate_clock_oe());
    dipr_src_model i_dipr_src_model (.*);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // one count per double-rate pulse
    always @(posedge double_rate_clock_out) dbl_rises++;
    // one count per rise of the divider clock
    always @(posedge sample_clock_pin_out) sclk_rises++;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one channel edge; the model holds it half a period, room for sync and push
    task automatic send(input logic [15:0] p1, input logic [15:0] p2);
        i_dipr_src_model.put(p1, p2);
    endtask : send
    task automatic take(input logic [1:0] v, input logic [15:0] wi, input logic [15:0] wq);
        chk("valid", {14'h1, v}, {13'h0, out_valid, out_i_valid, out_q_valid});
        chk("i word", wi, out_i_word);
        chk("q word", wq, out_q_word);
        out_ready = 1'b1;
        @(negedge clock);
        out_ready = 1'b0;
    endtask : take
    task automatic t_dual();
        channel_select_polarity = 1'b1;
        repeat (2) send(16'ha5c3, 16'h9234);
        take(2'b11, 16'ha5c3, 16'h9234);
        repeat (2) send(16'h5a3c, 16'h6dcb);
        take(2'b11, 16'h5a3c, 16'h6dcb);
        chk("extra entry", 16'h0, {15'h0, out_valid});
        $display("dual port test done");
    endtask : t_dual
    task automatic t_single();
        single_port_mode = 1'b1;
        dbl_rises = 0;
        for (int k = 0; k < 4; k++) begin
            channel_select_polarity = k[1];
            send(16'h1c00 + 16'(k), {k[0], 15'h0});
            if (k[0] == k[1]) take(2'b01, 16'h0, 16'h1c00 + 16'(k));
            else take(2'b10, 16'h1c00 + 16'(k), 16'h0);
        end
        chk("double rate pulses", 16'h4, 16'(dbl_rises));
        $display("single port test done");
    endtask : t_single
    task automatic t_serial();
        logic [2:0] v;
        for (int k = 0; k < 8; k++) begin
            v = 3'(k);
            {serial_select_n, serial_pin_direction, instr_read} = v;
            {read_data, serial_data_in} = {!v[0], v[1]};
            repeat (5) @(negedge clock);
            chk("data out", {15'h0, !v[0]}, {15'h0, serial_data_out});
            chk("read pin out", {15'h0, !v[0]}, {15'h0, serial_read_pin_out});
            chk("write data", {15'h0, v[1]}, {15'h0, serial_write_data});
            chk("data oe", {15'h0, !v[2] && (!v[1] || v[0])}, {15'h0, serial_data_oe});
            chk("read oe", {15'h0, !v[2] && !v[1]}, {15'h0, serial_read_pin_oe});
        end
        $display("serial pin test done");
    endtask : t_serial
    // buffer filled past full, then drained to empty
    task automatic t_fill();
        int n;
        n = 0;
        for (int k = 0; k < 32; k++) send(16'(k), 16'h0);
        chk("overflow at full", 16'h0, {15'h0, overflow});
        send(16'hbeef, 16'h0);
        chk("overflow past full", 16'h1, {15'h0, overflow});
        out_ready = 1'b1;
        while (out_valid === 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        out_ready = 1'b0;
        chk("words drained", 16'h20, 16'(n));
        $display("fifo fill test done");
    endtask : t_fill
    task automatic t_reset();
        sample_clock_direction = 1'b1;
        sclk_rises = 0;
        repeat (16) @(negedge clock);
        chk("sample clock rises", 16'h2, 16'(sclk_rises));
        chk("divider pushes", 16'h1, {15'h0, out_valid});
        rst_n = 1'b0;
        sample_clock_direction = 1'b0;
        @(negedge clock);
        chk("valid in reset", 16'h0, {15'h0, out_valid});
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        chk("valid after reset", 16'h0, {15'h0, out_valid});
        chk("overflow after reset", 16'h0, {15'h0, overflow});
        $display("reset test done");
    endtask : t_reset
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    initial begin
        {rst_n, out_ready, single_port_mode, channel_select_polarity} = 4'h0;
        {sample_clock_direction, serial_pin_direction, serial_select_n, instr_read} = 4'h2;
        {read_data, serial_data_in} = 2'h0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_dual();
        t_single();
        t_serial();
        t_fill();
        t_reset();
        report_and_stop();
    end
    // hang guard; the tests need about 5.5 us
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
endmodule : tb
